// file: design/carrier_map.vh
`ifndef CARRIER_MAP_VH
`define CARRIER_MAP_VH

// local control register offsets within the board window
`define CARRIER_CONTROL_OFS        12'h500
`define SLOT_INTERRUPT_STATUS_OFS  12'h600
`define CARRIER_STATUS_OFS         12'h700
`define CARRIER_CONTROL_RESET      16'h0000

// carrier_control fields
`define CTL_SLOT_A_CLK_BIT   0
`define CTL_SLOT_D_CLK_BIT   3
`define CTL_ARM_BIT          4
`define CTL_AUTO_ACK_BIT     5
`define CTL_INT_EN_BIT       6
`define CTL_SW_INT_BIT       7
`define CTL_SLOT_E_CLK_BIT   8
`define CTL_SLOT_F_CLK_BIT   9
`define CTL_WRITE_MASK       16'h03ff

// carrier_status fields
`define STS_BUS_ERROR_BIT    6
`define STS_IRQ_COPY_BIT     7

// slot space codes and slot space layout
`define SPACE_IO             2'h0
`define SPACE_ID             2'h1
`define SPACE_INT            2'h2
`define SPACE_MEM            2'h3
`define NUM_SLOTS            6
`define STD_FIRST_SLOT_PAGE  3'h1
`define STD_FIRST_MEM_BLOCK  3'h2
`define RED_FIRST_SLOT_PAGE  4'h9
`define RED_FIRST_MEM_BLOCK  5'h0a
`define RED_MEM_BASE         16'h5000

// bus error timer
`define TIMEOUT_NS           3200
`define SYS_CLK_MHZ          10
// 3.2 us in whole 100 ns cycles, sized for the six-bit timer
`define TIMEOUT_CYCLES       6'h20

`endif

// file: design/pin_sync.v
`timescale 1ns/100ps
module pin_sync
#(
  parameter           WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
)
(
  input  wire             sys_clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta;

  // meta feeds only the second stage
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      meta     <= INIT;
      sync_out <= INIT;
    end
    else
    begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule // pin_sync

// file: design/module_carrier_local_control.v
// Notes on behaviour
// RQ1 - each module offers 128 id words, id data in low byte of first 12; ip_addr carries only A1-A6, 64 words
// RQ2 - id data: signature, maker, model, revision, driver, count, crc
// RQ3 - standard map decodes a full 8 MB memory window per slot
// RQ4 - reduced map: 2 KB per slot, slot A at module address zero
// RQ5 - every module interrupt level goes onto the single host interrupt
// RQ6 - slot status shows twelve request bits, each following its source
// RQ7 - interrupt raised when any slot bit set and enable is one
// RQ8 - interrupt space access runs a vector cycle, A1 picks request
// RQ9 - with auto-ack on, reply for module silent 3.2 us or absent
// RQ10 - timer reply only for valid slot addresses, none when disabled
// RQ11 - bus error flag held clear while arm is zero, else sticky on timeout
// RQ12 - software clears arm then sets it again to re-enable the flag
// RQ13 - armed bus error requests interrupt when enabled, else pollable
// RQ14 - with enable zero sources stay pending but request stays off
// RQ15 - software interrupt bit forces a request while enable is one
// RQ16 - per slot clock select: zero slow, one fast, bits 0-3 and 8-9
// RQ17 - bus sequencer paced by the addressed slot's clock each access
// RQ18 - on the slow-only variant clock selects have no effect
// RQ19 - control register word access, read-write, fields 4-7, reset zero
// RQ20 - summary status: bit 7 request copy, bit 6 bus error flag
// RQ21 - timer reply completes the pending host access with ready
// RQ22 - handler reads summary status first, then slot status
// RQ23 - request is OR of slot bits, armed flag, soft bit, gated by enable
`timescale 1ns/100ps
`include "carrier_map.vh"
module module_carrier_local_control
#(
  parameter FAST_CLOCK_FITTED = 1
)
(
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire        reduced_map_strap,
  input  wire        lb_req,
  input  wire        lb_write,
  input  wire [25:0] lb_addr,
  input  wire [1:0]  lb_be,
  input  wire [15:0] lb_wdata,
  output reg  [15:0] lb_rdata,
  output reg         lb_ready,
  input  wire        slow_clk_in,
  input  wire        fast_clk_in,
  output reg  [5:0]  slot_fast_sel,
  output reg  [5:0]  id_sel_n,
  output reg  [5:0]  io_sel_n,
  output reg  [5:0]  mem_sel_n,
  output reg  [5:0]  int_sel_n,
  output reg         ip_rw_n,
  output reg  [1:0]  ip_bs_n,
  output reg  [22:1] ip_addr,
  output reg  [15:0] ip_data_out,
  output reg         ip_data_oe,
  input  wire [15:0] ip_data_in,
  input  wire [5:0]  ip_ack_n,
  input  wire [5:0]  module_request0_n,
  input  wire [5:0]  module_request1_n,
  output reg         bridge_interrupt_request_n
);

  localparam ST_IDLE = 4'b0001;
  localparam ST_SEL  = 4'b0010;
  localparam ST_WAIT = 4'b0100;
  localparam ST_END  = 4'b1000;
  localparam [5:0] TIMEOUT_CYCLES = `TIMEOUT_CYCLES;

  // returns {hit, local, space[1:0], 1'b0, slot[2:0]}
  function [7:0] decode;
    input [25:0] a;
    input        red;
    reg   [3:0]  page;
    reg   [4:0]  blk;
    reg   [3:0]  s4;
    reg   [4:0]  s5;
    begin
      decode = 8'h00;
      page   = a[15:12];
      blk    = a[15:11];
      s4     = page - `RED_FIRST_SLOT_PAGE;
      s5     = blk - `RED_FIRST_MEM_BLOCK;
      if (a[25:12] == 14'h0000 && a[11:8] >= 4'h5 && a[11:8] <= 4'h7)
        decode = 8'hc0;
      else if (!red)
      begin
        if (a[25:15] == 11'h000 && a[14:12] >= 3'h1 &&
            a[14:12] <= 3'h6 && a[11:10] == 2'h0 && a[9:8] != 2'h3)
          decode = {2'b10, a[9:8], 1'b0,
                    a[14:12] - `STD_FIRST_SLOT_PAGE};
        else if (a[25:24] != 2'h0)
          decode = {2'b10, `SPACE_MEM, 1'b0,
                    a[25:23] - `STD_FIRST_MEM_BLOCK}; // RQ3
      end
      else if (a[25:16] == 10'h000)
      begin
        if (page >= 4'h9 && page <= 4'he &&
            a[11:10] == 2'h0 && a[9:8] != 2'h3)
          decode = {2'b10, a[9:8], 1'b0, s4[2:0]};
        else if (blk >= 5'h0a && blk <= 5'h0f)
          decode = {2'b10, `SPACE_MEM, 1'b0, s5[2:0]}; // RQ4
      end
    end
  endfunction

  reg  [3:0]  state;
  reg         map_reduced;
  reg  [15:0] ctl;
  reg  [11:0] slot_pending;
  reg         bus_error;
  reg         irq_level;
  reg  [2:0]  cur_slot;
  reg         cur_fast;
  reg  [5:0]  timer;
  reg         timer_ack;
  reg         slow_prev;
  reg         fast_prev;
  reg  [15:0] wdata_hold;
  reg  [1:0]  space_hold;
  reg         write_hold;
  wire [19:0] synced;
  wire [5:0]  ack_n_s;
  wire [5:0]  req0_n_s;
  wire [5:0]  req1_n_s;
  wire        slow_s;
  wire        fast_s;
  wire [7:0]  dec;
  wire [9:0]  fast_bits;
  wire [15:0] red_ofs;
  wire        pace;
  wire        take;
  wire        ack_seen;
  wire        timed_out;
  wire        ctl_write;
  wire [15:0] status_word;
  wire [11:0] next_pending;
  wire        next_bus_error;
  wire        next_irq;
  wire [5:0]  slot_onehot;

  pin_sync #(
    .WIDTH (20),
    .INIT  (20'hfffff)
  ) u_pin_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in ({fast_clk_in, slow_clk_in, module_request1_n,
                module_request0_n, ip_ack_n}),
    .sync_out (synced)
  );

  assign ack_n_s  = synced[5:0];
  assign req0_n_s = synced[11:6];
  assign req1_n_s = synced[17:12];
  assign slow_s   = synced[18];
  assign fast_s   = synced[19];

  // map size is a board option caught as reset is held
  always @(posedge sys_clk)
  begin
    if (!rst_n)
      map_reduced <= reduced_map_strap;
  end

  assign dec     = decode(lb_addr, map_reduced);
  assign red_ofs = lb_addr[15:0] - `RED_MEM_BASE;
  assign take    = (state == ST_IDLE) && lb_req && !lb_ready;

  // slow-only boards ignore the select bits but still read them back
  assign fast_bits = ctl[`CTL_SLOT_F_CLK_BIT:0];

  // clock edges are found by sampling; the select and end states only step on them
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      slow_prev <= 1'b1;
      fast_prev <= 1'b1;
    end
    else
    begin
      slow_prev <= slow_s;
      fast_prev <= fast_s;
    end
  end

  assign pace = cur_fast ? (fast_s && !fast_prev)
                         : (slow_s && !slow_prev); // RQ17

  assign slot_onehot = 6'h01 << cur_slot;
  assign ack_seen    = ((~ack_n_s) & slot_onehot) != 6'h00;
  assign timed_out   = ctl[`CTL_AUTO_ACK_BIT] &&
                       (timer >= TIMEOUT_CYCLES); // RQ9 RQ10

  assign ctl_write = take && lb_write && dec[6] &&
                     lb_addr[11:8] == `CARRIER_CONTROL_OFS >> 8;

  // module bus cycle sequencer
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state       <= ST_IDLE;
      cur_slot    <= 3'h0;
      cur_fast    <= 1'b0;
      timer       <= 6'h00;
      timer_ack   <= 1'b0;
      lb_ready    <= 1'b0;
      lb_rdata    <= 16'h0000;
      id_sel_n    <= 6'h3f;
      io_sel_n    <= 6'h3f;
      mem_sel_n   <= 6'h3f;
      int_sel_n   <= 6'h3f;
      ip_rw_n     <= 1'b1;
      ip_bs_n     <= 2'h3;
      ip_addr     <= 22'h000000;
      ip_data_out <= 16'h0000;
      ip_data_oe  <= 1'b0;
      wdata_hold  <= 16'h0000;
      space_hold  <= `SPACE_IO;
      write_hold  <= 1'b0;
    end
    else
    begin
      lb_ready  <= 1'b0;
      timer_ack <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (take && dec[7] && dec[6])
          begin
            lb_ready <= 1'b1;
            lb_rdata <= (lb_addr[9:8] == 2'h1) ? ctl :
                        (lb_addr[9:8] == 2'h2) ?
                        {4'h0, slot_pending} : status_word;
          end
          else if (take && dec[7])
          begin
            state      <= ST_SEL;
            cur_slot   <= dec[2:0];
            cur_fast   <= (FAST_CLOCK_FITTED != 0) &&
                          (dec[2:0] < 3'h4 ? fast_bits[dec[2:0]]
                           : fast_bits[{1'b0, dec[2:0]} + 4'h4]); // RQ18
            space_hold <= dec[5:4];
            write_hold <= lb_write;
            wdata_hold <= lb_wdata;
            ip_bs_n    <= ~lb_be;
            if (dec[5:4] == `SPACE_MEM)
              ip_addr <= map_reduced ? {8'h00, red_ofs[14:1]}
                                     : lb_addr[22:1]; // RQ3 RQ4
            else
              ip_addr <= {16'h0000, lb_addr[6:1]}; // RQ8
          end
          else if (take)
          begin
            // unmapped offsets answer at once with zero, never hang
            lb_ready <= 1'b1;
            lb_rdata <= 16'h0000;
          end
        end
        ST_SEL:
        begin
          if (pace)
          begin
            state       <= ST_WAIT;
            timer       <= 6'h00;
            ip_rw_n     <= !write_hold;
            ip_data_out <= wdata_hold;
            ip_data_oe  <= write_hold;
            case (space_hold)
              `SPACE_IO:  io_sel_n  <= ~slot_onehot;
              `SPACE_ID:  id_sel_n  <= ~slot_onehot;
              `SPACE_INT: int_sel_n <= ~slot_onehot; // RQ8
              default:    mem_sel_n <= ~slot_onehot;
            endcase
          end
        end
        ST_WAIT:
        begin
          if (timer != 6'h3f)
            timer <= timer + 6'h01;
          if (ack_seen || timed_out)
          begin
            state     <= ST_END;
            timer_ack <= !ack_seen && timed_out; // RQ9
            lb_rdata  <= ack_seen ? ip_data_in : 16'hffff;
          end
        end
        ST_END:
        begin
          if (pace)
          begin
            state      <= ST_IDLE;
            lb_ready   <= 1'b1; // RQ21
            id_sel_n   <= 6'h3f;
            io_sel_n   <= 6'h3f;
            mem_sel_n  <= 6'h3f;
            int_sel_n  <= 6'h3f;
            ip_rw_n    <= 1'b1;
            ip_bs_n    <= 2'h3;
            ip_data_oe <= 1'b0;
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // control register
  always @(posedge sys_clk)
  begin
    if (!rst_n)
      ctl <= `CARRIER_CONTROL_RESET; // RQ19
    else if (ctl_write)
      ctl <= lb_wdata & `CTL_WRITE_MASK; // RQ19 RQ16
  end

  always @(posedge sys_clk)
  begin
    if (!rst_n)
      slot_fast_sel <= 6'h00;
    else if (FAST_CLOCK_FITTED != 0)
      slot_fast_sel <= {ctl[`CTL_SLOT_F_CLK_BIT:`CTL_SLOT_E_CLK_BIT],
                        ctl[`CTL_SLOT_D_CLK_BIT:`CTL_SLOT_A_CLK_BIT]};
    else
      slot_fast_sel <= 6'h00; // RQ18
  end

  // pending bits interleave request 0 and 1 per slot, A low
  genvar g;
  generate
    for (g = 0; g < `NUM_SLOTS; g = g + 1)
    begin : g_pend
      assign next_pending[2*g]   = !req0_n_s[g]; // RQ6
      assign next_pending[2*g+1] = !req1_n_s[g]; // RQ6
    end
  endgenerate

  // arm low holds the flag clear; an arm write cannot meet a timeout
  // because the bus has only one access outstanding
  assign next_bus_error = ctl[`CTL_ARM_BIT] &&
                          (bus_error || timer_ack); // RQ11 RQ12

  assign next_irq = ctl[`CTL_INT_EN_BIT] &&
                    ((|slot_pending) ||
                     bus_error ||
                     ctl[`CTL_SW_INT_BIT]); // RQ5 RQ7 RQ13 RQ14 RQ15 RQ23

  assign status_word = {8'h00, irq_level, bus_error, 6'h00}; // RQ20

  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      slot_pending               <= 12'h000;
      bus_error                  <= 1'b0;
      irq_level                  <= 1'b0;
      bridge_interrupt_request_n <= 1'b1;
    end
    else
    begin
      slot_pending               <= next_pending; // RQ6
      bus_error                  <= next_bus_error; // RQ11
      irq_level                  <= next_irq; // RQ7
      bridge_interrupt_request_n <= !next_irq; // RQ5 RQ14
    end
  end

endmodule // module_carrier_local_control

// file: dv/carrier_checker.sv
`timescale 1ns/100ps
module carrier_checker
#(
  parameter FAST_CLOCK_FITTED = 1
)
(
  input wire        sys_clk,
  input wire        rst_n,
  input wire        lb_req,
  input wire        lb_write,
  input wire [25:0] lb_addr,
  input wire [15:0] lb_wdata,
  input wire [15:0] lb_rdata,
  input wire        lb_ready,
  input wire [5:0]  slot_fast_sel,
  input wire [5:0]  id_sel_n,
  input wire [5:0]  io_sel_n,
  input wire [5:0]  mem_sel_n,
  input wire [5:0]  int_sel_n,
  input wire [22:1] ip_addr,
  input wire [5:0]  module_request0_n,
  input wire [5:0]  module_request1_n,
  input wire        bridge_interrupt_request_n
);
  reg  [15:0] ctl;
  wire        sel = ~&{id_sel_n, io_sel_n, mem_sel_n, int_sel_n};
  wire        req = ~&{module_request0_n, module_request1_n};
  wire        irq = ~bridge_interrupt_request_n;
  // shadow lags the design a cycle, so windows are two or more long
  always @(posedge sys_clk)
    if (!rst_n)
      ctl <= 16'h0000;
    else if (lb_req && lb_ready && lb_write && lb_addr == 26'h500)
      ctl <= lb_wdata & 16'h03ff;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_enable_off;
    !ctl[6] [*2] |-> !irq;
  endproperty
  a_enable_off: assert property (p_enable_off)
    else $error("request while disabled");
  property p_soft_int;
    (ctl[6] && ctl[7]) [*2] |-> irq;
  endproperty
  a_soft_int: assert property (p_soft_int)
    else $error("soft request missing");
  property p_slot_int;
    (ctl[6] && req) [*6] |-> irq;
  endproperty
  a_slot_int: assert property (p_slot_int)
    else $error("slot request missing");
  property p_clock_sel;
    $stable(ctl) [*3] |-> slot_fast_sel ==
      ({ctl[9:8], ctl[3:0]} & {6{FAST_CLOCK_FITTED != 0}});
  endproperty
  a_clock_sel: assert property (p_clock_sel)
    else $error("clock select mismatch");
  property p_auto_ack;
    $rose(sel) && ctl[5] |-> ##[1:80] !sel;
  endproperty
  a_auto_ack: assert property (p_auto_ack)
    else $error("no timer reply");
  property p_release_ready;
    $fell(sel) |-> lb_ready;
  endproperty
  a_release_ready: assert property (p_release_ready)
    else $error("ready missing at release");
  property p_vector_word;
    !(&int_sel_n) |-> ip_addr[1] == lb_addr[1];
  endproperty
  a_vector_word: assert property (p_vector_word)
    else $error("vector word mismatch");
  property p_flag_held;
    lb_ready && !lb_write && lb_addr == 26'h700 && !ctl[4] |-> !lb_rdata[6];
  endproperty
  a_flag_held: assert property (p_flag_held)
    else $error("flag set while disarmed");
endmodule // carrier_checker

bind module_carrier_local_control carrier_checker
  #(.FAST_CLOCK_FITTED(FAST_CLOCK_FITTED))
  i_carrier_checker (.*);

// file: dv/slot_modules.sv
`timescale 1ns/100ps
module slot_modules
(
  input  wire        slot_clk,
  input  wire [5:0]  sel_n,
  input  wire [5:0]  id_sel_n,
  input  wire [22:1] ip_addr,
  input  wire [5:0]  present,
  output reg  [5:0]  ip_ack_n = 6'h3f,
  output reg  [15:0] ip_data_in = 16'h0000
);
  reg     done = 1'b0;
  integer s;
  // identification bytes; signature and maker values are arbitrary
  function [7:0] id_byte(input [5:0] w);
    begin
      case (w)
        6'h00:   id_byte = 8'h5a;
        6'h01:   id_byte = 8'h3c;
        6'h02:   id_byte = 8'h69;
        6'h03:   id_byte = 8'h0f;
        6'h04:   id_byte = 8'h21;
        6'h05:   id_byte = 8'h42;
        6'h06:   id_byte = 8'h01;
        6'h0a:   id_byte = 8'h0c;
        default: id_byte = 8'h00;
      endcase
    end
  endfunction
  // ack lasts one slot clock; an absent slot never answers
  always @(posedge slot_clk)
    if (ip_ack_n != 6'h3f)
    begin
      ip_ack_n   <= 6'h3f;
      ip_data_in <= ~ip_data_in;
    end
    else if (&sel_n)
      done <= 1'b0;
    else if (!done)
      for (s = 0; s < 6; s = s + 1)
        if (!sel_n[s] && present[s])
        begin
          ip_ack_n[s] <= 1'b0;
          ip_data_in  <= (&id_sel_n) ? {5'h18, s[2:0], 2'h0, ip_addr[6:1]}
                         : {8'h00, id_byte(ip_addr[6:1])};
          done        <= 1'b1;
        end
endmodule // slot_modules

// file: dv/testbench.sv
`timescale 1ns/100ps
module testbench;
  reg         sys_clk, rst_n, lb_req, lb_write, slow_clk_in, fast_clk_in;
  reg  [25:0] lb_addr, a;
  reg  [15:0] lb_wdata, rd, e;
  reg  [5:0]  module_request0_n, module_request1_n, present;
  reg  [31:0] rng;
  wire [15:0] lb_rdata, ip_data_out, ip_data_in;
  wire [22:1] ip_addr;
  wire [5:0]  slot_fast_sel, id_sel_n, io_sel_n, mem_sel_n, int_sel_n;
  wire [5:0]  ip_ack_n;
  wire [1:0]  ip_bs_n;
  wire        lb_ready, ip_rw_n, ip_data_oe, bridge_interrupt_request_n;
  reg         reduced_map_strap;
  wire [1:0]  lb_be = 2'h3;
  integer     err_total, checks, cyc, s, k;

  module_carrier_local_control i_module_carrier_local_control (.*);
  slot_modules i_slot_modules
  (
    .slot_clk   (slow_clk_in),
    .sel_n      (id_sel_n & io_sel_n & mem_sel_n & int_sel_n),
    .id_sel_n   (id_sel_n),
    .ip_addr    (ip_addr),
    .present    (present),
    .ip_ack_n   (ip_ack_n),
    .ip_data_in (ip_data_in)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always #400 slow_clk_in = ~slow_clk_in;
  always #195 fast_clk_in = ~fast_clk_in;

  function [31:0] xs(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
    end
  endfunction

  task test_done;
    begin
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  task cmp(input [15:0] got, input [15:0] want);
    begin
      checks = checks + 1;
      if (got !== want)
      begin
        err_total = err_total + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, want);
      end
    end
  endtask

  // request held through the edge that samples ready high
  task acc(input w, input [25:0] ad, input [15:0] d);
    begin
      lb_write = w;
      lb_addr  = ad;
      lb_wdata = d;
      lb_req   = 1'b1;
      @(negedge sys_clk);
      while (lb_ready !== 1'b1)
        @(negedge sys_clk);
      rd = lb_rdata;
      @(negedge sys_clk);
      lb_req = 1'b0;
      @(negedge sys_clk);
    end
  endtask

  always @(posedge sys_clk)
  begin
    cyc = cyc + 1;
    if (cyc > 8000)
    begin
      err_total = err_total + 1;
      test_done;
    end
  end

  initial
  begin
    {reduced_map_strap, lb_req, lb_write, rst_n} = 4'h0;
    {slow_clk_in, fast_clk_in} = 2'h0;
    {lb_addr, lb_wdata} = 42'h0;
    {module_request0_n, module_request1_n, present} = 18'h3ffff;
    {err_total, checks, cyc} = 96'h0;
    rng = 32'h00000012;
    repeat (8) @(negedge sys_clk);
    rst_n = 1'b1;
    acc(1'b0, 26'h500, 16'h0000);
    cmp(rd, 16'h0000);
    acc(1'b0, 26'h480, 16'h0000);
    cmp(rd, 16'h0000);
    acc(1'b1, 26'h500, 16'hffff);
    acc(1'b0, 26'h500, 16'h0000);
    cmp(rd, 16'h03ff);
    cmp({10'h000, slot_fast_sel}, 16'h003f);
    $display("register test done");
    for (k = 0; k < 9; k = k + 1)
    begin
      rng = xs(rng);
      module_request0_n = (k == 8) ? 6'h3f : rng[5:0];
      module_request1_n = (k == 8) ? 6'h3f : rng[13:8];
      acc(1'b1, 26'h500, {9'h000, rng[16], 6'h00});
      e = 16'h0000;
      for (s = 0; s < 6; s = s + 1)
        e[2*s +: 2] = ~{module_request1_n[s], module_request0_n[s]};
      repeat (4) @(negedge sys_clk);
      acc(1'b0, 26'h600, 16'h0000);
      cmp(rd, e);
      cmp({15'h0, bridge_interrupt_request_n}, {15'h0, !(rng[16] && e != 0)});
      acc(1'b0, 26'h700, 16'h0000);
      cmp(rd, {8'h00, rng[16] && e != 0, 7'h00});
    end
    acc(1'b1, 26'h500, 16'h00c0);
    acc(1'b0, 26'h700, 16'h0000);
    cmp(rd, 16'h0080);
    acc(1'b1, 26'h500, 16'h0080);
    acc(1'b0, 26'h700, 16'h0000);
    cmp(rd, 16'h0000);
    $display("interrupt test done");
    for (s = 0; s < 6; s = s + 1)
      for (k = 0; k < 4; k = k + 1)
      begin
        rng = xs(rng);
        if (k == 3)
          a = {10'h000, s[3:0] + 4'd1, 12'h10e};
        else if (k == 2)
          a = {s[2:0] + 3'd2, rng[22:1], 1'b0};
        else
          a = {10'h000, s[3:0] + 4'd1, 4'h2, 1'b0, rng[6:2], k[0], 1'b0};
        acc(1'b0, a, 16'h0000);
        cmp(rd, (k == 3) ? 16'h0000
                         : {5'h18, s[2:0], 2'h0, a[6:1]});
      end
    $display("slot access test done");
    present = 6'h1f;
    for (k = 0; k < 2; k = k + 1)
    begin
      acc(1'b1, 26'h500, {10'h000, 1'b1, k[0], 4'h0});
      acc(1'b0, 26'h6100, 16'h0000);
      cmp(rd, 16'hffff);
      acc(1'b0, 26'h700, 16'h0000);
      cmp(rd, {9'h000, k[0], 6'h00});
    end
    acc(1'b1, 26'h500, 16'h0070);
    acc(1'b0, 26'h700, 16'h0000);
    cmp(rd, 16'h00c0);
    acc(1'b1, 26'h500, 16'h0060);
    acc(1'b0, 26'h700, 16'h0000);
    cmp(rd, 16'h0000);
    acc(1'b1, 26'h500, 16'h0030);
    acc(1'b1, 26'h6000, 16'ha5c3);
    acc(1'b0, 26'h700, 16'h0000);
    cmp(rd, 16'h0040);
    $display("timeout test done");
    reduced_map_strap = 1'b1;
    rst_n = 1'b0;
    repeat (8) @(negedge sys_clk);
    rst_n = 1'b1;
    present = 6'h3f;
    acc(1'b0, 26'h500, 16'h0000);
    cmp(rd, 16'h0000);
    acc(1'b0, 26'h700, 16'h0000);
    cmp(rd, 16'h0000);
    for (s = 0; s < 6; s = s + 1)
    begin
      rng = xs(rng);
      a = 26'h5000 + {12'h000, s[2:0], 11'h000} + {15'h0000, rng[10:1], 1'b0};
      acc(1'b0, a, 16'h0000);
      cmp(rd, {5'h18, s[2:0], 2'h0, a[6:1]});
      cmp(ip_addr[16:1], {3'h0, s[2:0], rng[10:1]});
      a = {10'h000, s[3:0] + 4'h9, 4'h2, 1'b0, rng[6:1], 1'b0};
      acc(1'b0, a, 16'h0000);
      cmp(rd, {5'h18, s[2:0], 2'h0, a[6:1]});
    end
    $display("reduced map test done");
    test_done;
  end
endmodule // testbench
